// ===== rtl/uotg_pkg.sv
// Purpose: Shared constants and carrier types for the USB OTG status block
// Assumes: APB register access, one 100 MHz clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
package uotg_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_PLL    = 8'h00;
  localparam logic [7:0] ADDR_OTGIR  = 8'h04;
  localparam logic [7:0] ADDR_SOF    = 8'h08;
  localparam logic [7:0] ADDR_BDTP   = 8'h0c;
  localparam logic [7:0] ADDR_UNLOCK = 8'h10;

  // Field positions
  localparam int PLL_ODIV_LSB  = 24;
  localparam int PLL_MULT_LSB  = 16;
  localparam int PLL_IDIV_LSB  = 8;
  localparam int BDTP_LSB      = 1;
  localparam int BDT_ADDR_LSB  = 9;
  localparam int FLAG_ID       = 7;
  localparam int FLAG_MS       = 6;
  localparam int FLAG_LINE     = 5;
  localparam int FLAG_ACTIVITY = 4;
  localparam int FLAG_DROP     = 3;
  localparam int FLAG_SES_END  = 2;
  localparam int FLAG_SES_VLD  = 0;

  // Reset values and implemented-bit masks
  localparam logic [7:0]  FLAG_RST  = 8'h00;
  localparam logic [7:0]  FLAG_MASK = 8'hfd;
  localparam logic [7:0]  SOF_RST   = 8'h00;
  localparam logic [6:0]  BDTP_RST  = 7'h00;

  // Unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h5a5a0001;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5a5a0002;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} uotg_lock_t;

  typedef struct packed {
    logic [2:0] out_div;
    logic [2:0] mult;
    logic [2:0] in_div;
  } uotg_pll_cfg_t;

  typedef struct packed {
    logic [4:0] out_div;
    logic [4:0] mult;
    logic [3:0] in_div;
  } uotg_ratio_t;

  typedef struct packed {
    logic       id;
    logic [1:0] line_state;
    logic       sess_end;
    logic       sess_valid;
    logic       vbus_above_end;
    logic       asleep;
  } uotg_line_t;

endpackage

// ===== rtl/uotg_ms_timer.sv
// Purpose: Millisecond interval timer, free running or one shot
// Assumes: Restart is a synchronous pulse or level
// Notes:   Expired is a one-cycle pulse from a flip-flop
`timescale 1ns/1ns
module uotg_ms_timer #(
  parameter int unsigned CYCLES = 100000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Control
  input  wire logic restart,
  input  wire logic periodic,
  // Result
  output logic      expired
);
  localparam int W = $clog2(CYCLES);

  generate
    if (CYCLES < 2) begin : g_bad_cycles
      $error("uotg_ms_timer needs CYCLES of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         expired;
  } uotg_tmr_state_t;

  uotg_tmr_state_t q;
  uotg_tmr_state_t d;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (reset || restart) begin
      d.cnt = '0;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt == W'(CYCLES - 1)) begin
        d.expired = 1'b1;
        d.cnt = '0;
        d.run = periodic;
      end else begin
        d.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign expired = q.expired;
endmodule // uotg_ms_timer

// ===== rtl/uotg_status_pll.sv
// Purpose: USB PLL configuration and OTG status registers on APB
// Assumes: USB side inputs are synchronous to core_clk
// Notes:   One APB wait state on every access
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module uotg_status_pll
  import uotg_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Configuration bits and USB side inputs
  input  wire uotg_pll_cfg_t  cfg_pll,
  input  wire uotg_line_t     usb_in,
  // Block outputs
  output uotg_pll_cfg_t       pll_cfg,
  output uotg_ratio_t         pll_ratio,
  output logic                pll_unlocked,
  output logic      [7:0]     otg_flags,
  output logic      [7:0]     sof_threshold,
  output logic      [31:0]    bdt_base
);

  // The decoder compares whole byte addresses, so offsets must be
  // distinct aligned words
  generate
    if (MS_CYCLES_P < 2) begin : g_bad_ms
      $error("uotg_status_pll needs MS_CYCLES_P of at least 2");
    end
    if ((ADDR_PLL[1:0] | ADDR_OTGIR[1:0] | ADDR_SOF[1:0] |
         ADDR_BDTP[1:0] | ADDR_UNLOCK[1:0]) != 2'b00) begin : g_bad_align
      $error("uotg_status_pll needs word-aligned register offsets");
    end
    if (ADDR_PLL == ADDR_OTGIR || ADDR_SOF == ADDR_BDTP ||
        ADDR_UNLOCK == ADDR_PLL) begin : g_bad_map
      $error("uotg_status_pll needs distinct register offsets");
    end
    if (FLAG_MASK[1] != 1'b0) begin : g_bad_flags
      $error("uotg_status_pll keeps status bit 1 unimplemented");
    end
  endgenerate

  typedef struct packed {
    uotg_pll_cfg_t pll;
    uotg_lock_t    lock;
    logic          unlocked;
    logic [7:0]    flags;
    logic [7:0]    sof;
    logic [6:0]    bdtp;
    uotg_line_t    prev;
    logic [1:0]    stable_ls;
    uotg_ratio_t   ratio;
    logic [31:0]   base;
    logic [31:0]   rdata;
    logic          ready;
    logic          slverr;
  } uotg_state_t;

  uotg_state_t q;
  uotg_state_t d;

  logic ms_tick;
  logic line_tick;
  logic line_moved;

  // Output divider ratio
  function automatic logic [4:0] odiv_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h01;
    case (code)
      3'h0: r = 5'h01;
      3'h1: r = 5'h02;
      3'h2: r = 5'h03;
      3'h3: r = 5'h04;
      3'h4: r = 5'h06;
      3'h5: r = 5'h08;
      3'h6: r = 5'h0c;
      3'h7: r = 5'h10;
      default: r = 5'h01;
    endcase
    return r;
  endfunction

  // Multiplier ratio
  function automatic logic [4:0] mult_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h0f;
    case (code)
      3'h0: r = 5'h0f;
      3'h1: r = 5'h10;
      3'h2: r = 5'h11;
      3'h3: r = 5'h12;
      3'h4: r = 5'h13;
      3'h5: r = 5'h14;
      3'h6: r = 5'h15;
      3'h7: r = 5'h18;
      default: r = 5'h0f;
    endcase
    return r;
  endfunction

  // Input divider ratio; two codes share divide by three
  function automatic logic [3:0] idiv_ratio(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h1;
    case (code)
      3'h0: r = 4'h1;
      3'h1: r = 4'h3;
      3'h2: r = 4'h3;
      3'h3: r = 4'h4;
      3'h4: r = 4'h5;
      3'h5: r = 4'h6;
      3'h6: r = 4'ha;
      3'h7: r = 4'hc;
      default: r = 4'h1;
    endcase
    return r;
  endfunction

  // Edge events of the cable levels; activity only counts asleep
  function automatic logic [7:0] pin_events(input uotg_line_t now,
                                            input uotg_line_t was);
    logic [7:0] e;
    e = 8'h00;
    e[FLAG_ID]       = now.id != was.id;
    e[FLAG_ACTIVITY] = now.asleep &&
                       (now.line_state != was.line_state ||
                        now.id != was.id ||
                        now.vbus_above_end != was.vbus_above_end);
    e[FLAG_DROP]     = was.vbus_above_end && !now.vbus_above_end;
    e[FLAG_SES_END]  = now.sess_end != was.sess_end;
    e[FLAG_SES_VLD]  = now.sess_valid != was.sess_valid;
    return e;
  endfunction

  // Only the three code fields land; the rest of the word is dropped
  function automatic uotg_pll_cfg_t pll_fields(input logic [31:0] w);
    uotg_pll_cfg_t p;
    p.out_div = w[PLL_ODIV_LSB +: 3];
    p.mult    = w[PLL_MULT_LSB +: 3];
    p.in_div  = w[PLL_IDIV_LSB +: 3];
    return p;
  endfunction

  // Key sequence; any stray value on the key register relocks
  function automatic uotg_lock_t next_lock(input uotg_lock_t cur,
                                           input logic [31:0] w);
    uotg_lock_t n;
    n = LK_LOCKED;
    if (w == UNLOCK_KEY1) begin
      n = LK_HALF;
    end else if (w == UNLOCK_KEY2 && cur == LK_HALF) begin
      n = LK_OPEN;
    end
    return n;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_PLL) || (a == ADDR_OTGIR) || (a == ADDR_SOF) ||
           (a == ADDR_BDTP) || (a == ADDR_UNLOCK);
  endfunction

  // Read mux; every bit not placed here reads zero
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input uotg_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      ADDR_PLL: begin
        w[PLL_ODIV_LSB +: 3] = s.pll.out_div;
        w[PLL_MULT_LSB +: 3] = s.pll.mult;
        w[PLL_IDIV_LSB +: 3] = s.pll.in_div;
      end
      ADDR_OTGIR: begin
        w[7:0] = s.flags & FLAG_MASK;
      end
      ADDR_SOF: begin
        w[7:0] = s.sof;
      end
      ADDR_BDTP: begin
        w[BDTP_LSB +: 7] = s.bdtp;
      end
      ADDR_UNLOCK: begin
        w[0] = (s.lock == LK_OPEN);
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  // Free running millisecond timer
  uotg_ms_timer #(
    .CYCLES (MS_CYCLES_P)
  ) u_ms_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .restart  (1'b0),
    .periodic (1'b1),
    .expired  (ms_tick)
  );

  // Line stability timer restarts on every line state change
  assign line_moved = (usb_in.line_state != q.prev.line_state);

  uotg_ms_timer #(
    .CYCLES (MS_CYCLES_P)
  ) u_line_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .restart  (line_moved),
    .periodic (1'b0),
    .expired  (line_tick)
  );

  always_comb begin
    logic       acc;
    logic       commit;
    logic       wr;
    logic [7:0] set;
    logic [7:0] clr;
    acc    = psel && penable;
    commit = acc && q.ready;
    wr     = commit && pwrite;
    set    = 8'h00;
    clr    = 8'h00;
    d = q;
    if (reset) begin
      d.pll       = cfg_pll;
      d.lock      = LK_LOCKED;
      d.flags     = FLAG_RST;
      d.sof       = SOF_RST;
      d.bdtp      = BDTP_RST;
      d.prev      = usb_in;
      d.stable_ls = usb_in.line_state;
      d.rdata     = 32'h00000000;
      d.ready     = 1'b0;
      d.slverr    = 1'b0;
    end else begin
      // Flag sources
      set          = pin_events(usb_in, q.prev);
      set[FLAG_MS] = ms_tick;
      if (line_tick && !line_moved &&
          usb_in.line_state != q.stable_ls) begin
        set[FLAG_LINE] = 1'b1;
        d.stable_ls    = usb_in.line_state;
      end
      d.prev = usb_in;

      // APB: one wait state, effects land on the sampling edge
      d.ready  = acc && !q.ready;
      d.rdata  = 32'h00000000;
      d.slverr = 1'b0;
      if (acc && !q.ready) begin
        d.slverr = !mapped(paddr);
        if (!pwrite) begin
          d.rdata = read_word(paddr, q);
        end
      end

      if (wr) begin
        case (paddr)
          ADDR_PLL: begin
            // Locked writes are dropped without an error
            if (q.lock == LK_OPEN) begin
              d.pll         = pll_fields(pwdata);
              d.lock        = LK_LOCKED;
            end
          end
          ADDR_OTGIR: begin
            clr = pwdata[7:0] & FLAG_MASK;
          end
          ADDR_SOF: begin
            d.sof = pwdata[7:0];
          end
          ADDR_BDTP: begin
            d.bdtp = pwdata[BDTP_LSB +: 7];
          end
          ADDR_UNLOCK: begin
            d.lock = next_lock(q.lock, pwdata);
          end
          default: begin
            d.lock = q.lock;
          end
        endcase
      end

      // Hardware set beats a same-cycle clear
      d.flags = ((q.flags & ~clr) | set) & FLAG_MASK;
    end

    // Derived outputs
    d.ratio.out_div = odiv_ratio(d.pll.out_div);
    d.ratio.mult    = mult_ratio(d.pll.mult);
    d.ratio.in_div  = idiv_ratio(d.pll.in_div);
    d.unlocked      = (d.lock == LK_OPEN);
    d.base          = 32'h00000000;
    d.base[BDT_ADDR_LSB +: 7] = d.bdtp;
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign prdata        = q.rdata;
  assign pready        = q.ready;
  assign pslverr       = q.slverr;
  assign pll_cfg       = q.pll;
  assign pll_ratio     = q.ratio;
  assign pll_unlocked  = q.unlocked;
  assign otg_flags     = q.flags;
  assign sof_threshold = q.sof;
  assign bdt_base      = q.base;

endmodule // uotg_status_pll

// ===== verification/uotg_usb_peer.sv
// Purpose: Cable-side model that drives the USB line levels
// Assumes: Levels change only on core_clk rising edges
// Notes:   Lag delays each new cable state by 0 to 7 cycles
`timescale 1ns/1ns
module uotg_usb_peer
  import uotg_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Requested cable state and its delay
  input  wire uotg_line_t want,
  input  wire logic [2:0] lag,
  // Levels seen by the device
  output uotg_line_t      usb_in
);
  logic [2:0] cnt_q;
  // A slow cable settles late, so flags may trail the request
  always_ff @(posedge core_clk) begin
    if (reset || want == usb_in) begin
      usb_in <= reset ? want : usb_in;
      cnt_q  <= 3'h0;
    end else if (cnt_q >= lag) begin
      usb_in <= want;
      cnt_q  <= 3'h0;
    end else begin
      cnt_q  <= cnt_q + 3'h1;
    end
  end
endmodule // uotg_usb_peer

// ===== verification/uotg_status_pll_monitor.sv
// Purpose: Port checks of the USB status and PLL block
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind below
`timescale 1ns/1ns
module uotg_status_pll_monitor
  import uotg_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  // Clock and reset
  input logic          core_clk,
  input logic          reset,
  // APB
  input logic          psel,
  input logic          penable,
  input logic          pwrite,
  input logic [7:0]    paddr,
  input logic [31:0]   pwdata,
  input logic [31:0]   prdata,
  input logic          pready,
  input logic          pslverr,
  // Block side
  input uotg_line_t    usb_in,
  input uotg_pll_cfg_t pll_cfg,
  input logic          pll_unlocked,
  input logic [7:0]    otg_flags,
  input logic [31:0]   bdt_base
);
  logic [7:0] clr_m;
  assign clr_m = (psel && penable && pready && pwrite &&
                  paddr == ADDR_OTGIR) ? pwdata[7:0] : 8'h00;
  logic       rst_tail_q;
  // First edge after reset still looks back at unknown history
  always_ff @(posedge core_clk) begin
    rst_tail_q <= reset;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset || rst_tail_q);
  sequence first_acc;
    psel && $rose(penable);
  endsequence
  sequence answer;
    !pready ##1 pready;
  endsequence
  apb_wait_a: assert property (first_acc |-> answer)
    else $error("apb answer late");
  unmapped_err_a: assert property (first_acc ##0 paddr >= 8'h14
    |=> pready && pslverr && prdata == 32'h0) else $error("no slverr");
  pll_lock_a: assert property (psel && penable && pready && pwrite
    && paddr == ADDR_PLL && !pll_unlocked |=> $stable(pll_cfg))
    else $error("locked pll written");
  flag_clear_a: assert property
    ((($past(otg_flags) & ~$past(clr_m)) & ~otg_flags) == 8'h00)
    else $error("flag lost");
  bit1_zero_a: assert property (!otg_flags[1])
    else $error("flag bit 1 set");
  bdt_align_a: assert property (bdt_base[8:0] == 9'h0
    && bdt_base[31:16] == 16'h0) else $error("base misaligned");
  id_flag_a: assert property ($changed(usb_in.id)
    |-> ##[0:2] otg_flags[FLAG_ID]) else $error("id flag");
  drop_flag_a: assert property ($fell(usb_in.vbus_above_end)
    |-> ##[0:2] otg_flags[FLAG_DROP]) else $error("drop flag");
  end_flag_a: assert property ($changed(usb_in.sess_end)
    |-> ##[0:2] otg_flags[FLAG_SES_END]) else $error("end flag");
  valid_flag_a: assert property ($changed(usb_in.sess_valid)
    |-> ##[0:2] otg_flags[FLAG_SES_VLD]) else $error("valid flag");
endmodule // uotg_status_pll_monitor

bind uotg_status_pll uotg_status_pll_monitor
  #(.MS_CYCLES_P(MS_CYCLES_P)) u_mon (.core_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .usb_in, .pll_cfg, .pll_unlocked, .otg_flags, .bdt_base);

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the status and PLL block
// Assumes: Millisecond count cut to 20 cycles
// Notes:   Cable side comes from the peer model
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
  import uotg_pkg::*;
;
  localparam int MS = 20;
  logic          core_clk = 1'b0;
  logic          reset    = 1'b1;
  logic          psel     = 1'b0;
  logic          penable  = 1'b0;
  logic          pwrite   = 1'b0;
  logic [7:0]    paddr    = 8'h00;
  logic [31:0]   pwdata   = 32'h0;
  logic [2:0]    lag      = 3'h0;
  uotg_line_t    want     = 7'h02;
  uotg_pll_cfg_t cfg_pll  = 9'h000;
  uotg_pll_cfg_t pll_cfg, c;
  uotg_line_t    usb_in;
  uotg_ratio_t   pll_ratio;
  logic [31:0]   prdata, bdt_base, rd;
  logic [7:0]    otg_flags, sof_threshold, v;
  logic          pready, pslverr, pll_unlocked, err;
  int            errors = 0;
  int            checks_done = 0;
  logic [7:0]    tv [4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};

  always #5 core_clk = ~core_clk;
  uotg_status_pll #(.MS_CYCLES_P(MS)) u_dut (.core_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cfg_pll, .usb_in, .pll_cfg, .pll_ratio, .pll_unlocked, .otg_flags,
    .sof_threshold, .bdt_base);
  uotg_usb_peer u_peer (.core_clk, .reset, .want, .lag, .usb_in);

  function automatic uotg_ratio_t dec(uotg_pll_cfg_t x);
    int od [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    int mu [8] = '{15, 16, 17, 18, 19, 20, 21, 24};
    int id [8] = '{1, 3, 3, 4, 5, 6, 10, 12};
    return {5'(od[x.out_div]), 5'(mu[x.mult]), 4'(id[x.in_div])};
  endfunction

  function automatic logic [31:0] pll_word(uotg_pll_cfg_t x);
    return {5'h0, x.out_div, 5'h0, x.mult, 5'h0, x.in_div, 8'h00};
  endfunction

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h40076acf));
    cfg_pll <= 9'($urandom);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    `CHK("pll_cfg", cfg_pll, pll_cfg)
    `CHK("ratio", dec(cfg_pll), pll_ratio)
    apb(1'b1, ADDR_PLL, 32'h0);
    apb(1'b0, ADDR_PLL, 32'h0);
    `CHK("locked", pll_word(cfg_pll), rd)
    for (int i = 0; i < 8; i++) begin
      c = {3'(i), 3'(7 - i), 3'(i)};
      apb(1'b1, ADDR_UNLOCK, UNLOCK_KEY1);
      apb(1'b1, ADDR_UNLOCK, UNLOCK_KEY2);
      apb(1'b0, ADDR_UNLOCK, 32'h0);
      `CHK("key_rd", 32'h1, rd)
      `CHK("open", 1'b1, pll_unlocked)
      apb(1'b1, ADDR_PLL, pll_word(c) | 32'hf8f8f8ff);
      `CHK("consumed", 1'b0, pll_unlocked)
      apb(1'b0, ADDR_PLL, 32'h0);
      `CHK("pll_rd", pll_word(c), rd)
      `CHK("ratio", dec(c), pll_ratio)
    end
    apb(1'b1, ADDR_PLL, 32'h0);
    `CHK("relock", c, pll_cfg)
    apb(1'b1, ADDR_UNLOCK, UNLOCK_KEY1);
    apb(1'b1, ADDR_UNLOCK, 32'h0);
    apb(1'b1, ADDR_UNLOCK, UNLOCK_KEY2);
    `CHK("stray_key", 1'b0, pll_unlocked)
    apb(1'b1, ADDR_PLL, 32'h0);
    `CHK("stray_pll", c, pll_cfg)
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? tv[i] : 8'($urandom);
      apb(1'b1, ADDR_SOF, {24'hffffff, v});
      apb(1'b0, ADDR_SOF, 32'h0);
      `CHK("sof", {24'h0, v}, rd)
      `CHK("sof_out", v, sof_threshold)
    end
    v = 8'($urandom);
    apb(1'b1, ADDR_BDTP, {24'hffffff, v});
    apb(1'b0, ADDR_BDTP, 32'h0);
    `CHK("page", {24'h0, v & 8'hfe}, rd)
    `CHK("base", {16'h0, v[7:1], 9'h0}, bdt_base)
    apb(1'b1, 8'h14, 32'hffffffff);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b1, ADDR_OTGIR, 32'hff);
    want.asleep <= 1'b1;
    repeat (4) @(posedge core_clk);
    lag  <= 3'($urandom);
    want <= 7'h5d;
    repeat (MS + 12) @(posedge core_clk);
    apb(1'b0, ADDR_OTGIR, 32'h0);
    `CHK("flags", 32'hfd, rd)
    apb(1'b1, ADDR_OTGIR, 32'h0);
    apb(1'b0, ADDR_OTGIR, 32'h0);
    `CHK("keep", 32'hfd, rd)
    apb(1'b1, ADDR_OTGIR, 32'hff);
    apb(1'b0, ADDR_OTGIR, 32'h0);
    `CHK("clear", 32'h0, rd & 32'hbf)
    repeat (MS + 2) @(posedge core_clk);
    `CHK("ms", 1'b1, otg_flags[FLAG_MS])
    conclude();
  end
endmodule // tb_top
